// [verilog/ctr_device.sv]
`timescale 1ns/1ps
// Functional notes
// R1 - No-retry burst: only two requests transmitted
// R2 - Extra requests cleared, others flags kept
// R3 - Sent: clear request, new-data; pending if enabled
// R4 - Retransmit mode serves every request
// R5 - Host avoids concurrent requests without retry
// R6 - No-retry mode never retries a failed frame
// R7 - Host re-requests failed no-retry frames
// R8 - Per-object request, new-data, pending visible
// R9 - Last object disable in prep may stick
// R10 - Stuck request still reads as pending
// R11 - Sticks only when sole pending object
// R12 - Bus activity or other request unsticks
// R13 - Other objects never stick
// R14 - Host reuses objects by reloading content
// R15 - Reloaded content sent next, old unaffected
// R16 - Lowest-numbered pending object sent first
module ctr_device
   import ctr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Host link
   ctr_link_if.device lnk,
   // CAN side
   input wire logic bus_activity,
   input wire logic bus_error,
   output logic tx_start,
   output logic [CTR_OBJ_W-1:0] tx_obj,
   output logic [CTR_ID_W-1:0] tx_id,
   output logic [CTR_DLC_W-1:0] tx_dlc,
   output logic [CTR_DATA_W-1:0] tx_data
);
   localparam int N = CTR_NUM_OBJ;
   localparam logic [CTR_OBJ_W-1:0] LAST = CTR_OBJ_W'(N - 1);

   typedef enum logic [1:0] {PH_IDLE, PH_PREP, PH_SEND} ctr_phase_e;

   logic [CTR_ID_W-1:0] obj_id [N];
   logic [CTR_DLC_W-1:0] obj_dlc [N];
   logic [CTR_DATA_W-1:0] obj_data [N];
   logic [N-1:0] txrq;
   logic [N-1:0] newd;
   logic [N-1:0] ipnd;
   logic [N-1:0] irq_en;
   logic [N-1:0] dis;
   logic stuck;
   ctr_phase_e phase;
   logic [CTR_OBJ_W-1:0] cur;
   logic reloaded;
   logic [3:0] prep_cnt;
   logic [7:0] frm_cnt;
   logic [1:0] burst_cnt;
   logic act_s1;
   logic act_s2;
   logic err_s1;
   logic err_s2;

   ////////////////////////////////////////////////////////////////////////////
   // Selection
   wire [N-1:0] eligible = txrq & ~dis;
   wire found;
   wire [CTR_OBJ_W-1:0] pick;
   ctr_pick #(.N(N)) u_pick
   (
      .req(eligible),
      .found(found),
      .idx(pick)
   ); // R16
   wire [N-1:0] others = txrq & ~(N'(1) << LAST);
   wire sole_last = txrq[LAST] && (others == '0); // R11
   wire load_sets = lnk.load_valid && lnk.load_transmit_request;
   wire other_set = load_sets && (lnk.load_obj != LAST);
   wire unstick = act_s2 || other_set; // R12
   wire no_retry = lnk.disable_auto_retransmit;
   // Burst of concurrent requests counted from idle; with retransmission off, third onward is dropped
   wire drop_now = no_retry && (burst_cnt >= 2'(CTR_NORETRY_SERVED)); // R1 R4
   wire frame_done = (phase == PH_SEND) && (frm_cnt == CTR_FRAME_CYC);
   wire frame_fail = (phase == PH_SEND) && err_s2;
   wire ipnd_set = frame_done && irq_en[cur];
   wire cur_reload = lnk.load_valid && (lnk.load_obj == cur);
   wire dis_hit = lnk.dis_valid && !lnk.dis_enable;
   wire en_hit = lnk.dis_valid && lnk.dis_enable;
   wire stick_now = dis_hit && (lnk.dis_obj == LAST) && (phase == PH_PREP)
      && (cur == LAST) && sole_last; // R9 R13

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers
   always_ff @(posedge ref_clk)
   begin
      act_s1 <= bus_activity;
      act_s2 <= act_s1;
      err_s1 <= bus_error;
      err_s2 <= err_s1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Object storage; reload does not touch the frame already latched (R15)
   always_ff @(posedge ref_clk)
   begin
      if (lnk.load_valid)
      begin
         obj_id[lnk.load_obj] <= lnk.load_id;
         obj_dlc[lnk.load_obj] <= lnk.load_dlc;
         obj_data[lnk.load_obj] <= lnk.load_data; // R15
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Message handler
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         txrq <= '0;
         newd <= '0;
         ipnd <= '0;
         irq_en <= '0;
         dis <= '0;
         stuck <= 1'b0;
         phase <= PH_IDLE;
         cur <= '0;
         reloaded <= 1'b0;
         prep_cnt <= '0;
         frm_cnt <= '0;
         burst_cnt <= '0;
         tx_start <= 1'b0;
         tx_obj <= '0;
         tx_id <= '0;
         tx_dlc <= '0;
         tx_data <= '0;
      end
      else
      begin
         tx_start <= 1'b0;
         case (phase)
            PH_IDLE:
            begin
               if (!found)
                  burst_cnt <= '0;
               else if (drop_now)
                  txrq[pick] <= 1'b0; // R2
               else
               begin
                  cur <= pick;
                  prep_cnt <= '0;
                  phase <= PH_PREP;
               end
            end
            PH_PREP:
            begin
               prep_cnt <= prep_cnt + 4'h1;
               if (stick_now || dis[cur] || !txrq[cur])
                  phase <= PH_IDLE;
               else if (prep_cnt == CTR_PREP_CYC)
               begin
                  tx_start <= 1'b1;
                  tx_obj <= cur;
                  tx_id <= obj_id[cur];
                  tx_dlc <= obj_dlc[cur];
                  tx_data <= obj_data[cur];
                  frm_cnt <= '0;
                  reloaded <= 1'b0;
                  burst_cnt <= burst_cnt + 2'h1;
                  phase <= PH_SEND;
               end
            end
            PH_SEND:
            begin
               frm_cnt <= frm_cnt + 8'h01;
               if (cur_reload)
                  reloaded <= 1'b1; // R15
               if (frame_done)
               begin
                  // Content reloaded during the frame keeps its request for a later send
                  if (!(reloaded || cur_reload))
                  begin
                     txrq[cur] <= 1'b0; // R3
                     newd[cur] <= 1'b0; // R3
                  end
                  if (ipnd_set)
                     ipnd[cur] <= 1'b1; // R3
                  phase <= PH_IDLE;
               end
               else if (frame_fail)
               begin
                  if (no_retry && !(reloaded || cur_reload))
                     txrq[cur] <= 1'b0; // R6
                  phase <= PH_IDLE;
               end
            end
            default:
               phase <= PH_IDLE;
         endcase
         // Host writes after the handler, so a fresh load wins
         if (lnk.load_valid)
         begin
            txrq[lnk.load_obj] <= lnk.load_transmit_request;
            newd[lnk.load_obj] <= lnk.load_new_data_flag;
            irq_en[lnk.load_obj] <= lnk.load_transmit_interrupt_enable;
            // A pending flag set by a frame ending in the same cycle wins
            if (!lnk.load_transmit_interrupt_enable && !(ipnd_set && cur_reload))
               ipnd[lnk.load_obj] <= 1'b0;
         end
         if (dis_hit)
            dis[lnk.dis_obj] <= 1'b1;
         if (stick_now)
            stuck <= 1'b1; // R9
         // Re-enable is swallowed while stuck
         if (en_hit && !(stuck || stick_now) )
            dis[lnk.dis_obj] <= 1'b0;
         if (stuck && unstick)
         begin
            stuck <= 1'b0;
            dis[LAST] <= 1'b0; // R12
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status; stuck state is hidden from the request bits
   assign lnk.transmit_request = txrq; // R8 R10
   assign lnk.new_data_flag = newd; // R8
   assign lnk.interrupt_pending = ipnd; // R8
   assign lnk.busy = (phase != PH_IDLE);
endmodule : ctr_device

// [verilog/ctr_pkg.sv]
package ctr_pkg;
   localparam int CTR_NUM_OBJ = 32;
   localparam int CTR_ID_W = 11;
   localparam int CTR_DATA_W = 64;
   localparam int CTR_DLC_W = 4;
   localparam int CTR_OBJ_W = 5;
   // Software register offsets (word index)
   localparam logic [3:0] CTR_REG_CTRL = 4'h0;
   localparam logic [3:0] CTR_REG_OBJ = 4'h1;
   localparam logic [3:0] CTR_REG_ID = 4'h2;
   localparam logic [3:0] CTR_REG_DLC = 4'h3;
   localparam logic [3:0] CTR_REG_DLO = 4'h4;
   localparam logic [3:0] CTR_REG_DHI = 4'h5;
   localparam logic [3:0] CTR_REG_FLAGS = 4'h6;
   localparam logic [3:0] CTR_REG_CMD = 4'h7;
   localparam logic [3:0] CTR_REG_TXRQ = 4'h8;
   localparam logic [3:0] CTR_REG_NEWD = 4'h9;
   localparam logic [3:0] CTR_REG_IPND = 4'hA;
   localparam logic [3:0] CTR_REG_STAT = 4'hB;
   // Flag field positions in the interface flag word
   localparam int CTR_F_TXRQ = 0;
   localparam int CTR_F_NEWD = 1;
   localparam int CTR_F_IRQEN = 2;
   // Command codes
   localparam logic [1:0] CTR_CMD_LOAD = 2'h1;
   localparam logic [1:0] CTR_CMD_DISABLE = 2'h2;
   localparam logic [1:0] CTR_CMD_ENABLE = 2'h3;
   // Number of requests served together before the rest are dropped
   localparam int CTR_NORETRY_SERVED = 2;
   // Preparation window before a frame starts, in cycles
   localparam logic [3:0] CTR_PREP_CYC = 4'h4;
   // Frame transmission time on the bus side, in cycles
   localparam logic [7:0] CTR_FRAME_CYC = 8'h20;
   localparam logic CTR_NORETRY_RESET = 1'b0;
endpackage : ctr_pkg

// [verilog/ctr_link_if.sv]
`timescale 1ns/1ps
interface ctr_link_if;
   import ctr_pkg::*;
   // Object load from host
   logic load_valid;
   logic [CTR_OBJ_W-1:0] load_obj;
   logic [CTR_ID_W-1:0] load_id;
   logic [CTR_DLC_W-1:0] load_dlc;
   logic [CTR_DATA_W-1:0] load_data;
   logic load_transmit_request;
   logic load_new_data_flag;
   logic load_transmit_interrupt_enable;
   // Request disable/enable
   logic dis_valid;
   logic dis_enable;
   logic [CTR_OBJ_W-1:0] dis_obj;
   logic disable_auto_retransmit;
   // Status back to host
   logic [CTR_NUM_OBJ-1:0] transmit_request;
   logic [CTR_NUM_OBJ-1:0] new_data_flag;
   logic [CTR_NUM_OBJ-1:0] interrupt_pending;
   logic busy;
   modport device (input load_valid, load_obj, load_id, load_dlc, load_data,
      load_transmit_request, load_new_data_flag, load_transmit_interrupt_enable,
      dis_valid, dis_enable, dis_obj, disable_auto_retransmit,
      output transmit_request, new_data_flag, interrupt_pending, busy);
   modport host (output load_valid, load_obj, load_id, load_dlc, load_data,
      load_transmit_request, load_new_data_flag, load_transmit_interrupt_enable,
      dis_valid, dis_enable, dis_obj, disable_auto_retransmit,
      input transmit_request, new_data_flag, interrupt_pending, busy);
endinterface : ctr_link_if

// [verilog/ctr_pick.sv]
`timescale 1ns/1ps
module ctr_pick
   import ctr_pkg::*;
#(
   parameter int N = CTR_NUM_OBJ
)(
   // Request vector
   input wire logic [N-1:0] req,
   // Lowest set index
   output logic found,
   output logic [$clog2(N)-1:0] idx
);
   if (N < 2)
   begin : g_bad_n
      $error("ctr_pick needs at least two objects");
   end
   always_comb
   begin
      found = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            found = 1'b1;
            idx = i[$clog2(N)-1:0];
         end
      end
   end
endmodule : ctr_pick

// [verilog/ctr_host.sv]
`timescale 1ns/1ps
module ctr_host
   import ctr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Software port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // Link to controller
   ctr_link_if.host lnk
);
   logic no_retry;
   logic [CTR_OBJ_W-1:0] obj;
   logic [CTR_ID_W-1:0] id;
   logic [CTR_DLC_W-1:0] dlc;
   logic [CTR_DATA_W-1:0] data;
   logic [2:0] flags;
   logic load_v;
   logic dis_v;
   logic dis_en;

   wire wr_cmd = wr && (addr == CTR_REG_CMD);
   wire [1:0] cmd = wdata[1:0];
   // Content is reloaded whole rather than disabling a request (R14)
   wire do_load = wr_cmd && (cmd == CTR_CMD_LOAD); // R14 R7

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         no_retry <= CTR_NORETRY_RESET;
         obj <= '0;
         id <= '0;
         dlc <= '0;
         data <= '0;
         flags <= '0;
         load_v <= 1'b0;
         dis_v <= 1'b0;
         dis_en <= 1'b0;
      end
      else
      begin
         load_v <= do_load;
         dis_v <= wr_cmd && (cmd == CTR_CMD_DISABLE || cmd == CTR_CMD_ENABLE);
         dis_en <= (cmd == CTR_CMD_ENABLE);
         if (wr)
         begin
            case (addr)
               CTR_REG_CTRL: no_retry <= wdata[0];
               CTR_REG_OBJ: obj <= wdata[CTR_OBJ_W-1:0];
               CTR_REG_ID: id <= wdata[CTR_ID_W-1:0];
               CTR_REG_DLC: dlc <= wdata[CTR_DLC_W-1:0];
               CTR_REG_DLO: data[31:0] <= wdata;
               CTR_REG_DHI: data[63:32] <= wdata;
               CTR_REG_FLAGS: flags <= wdata[2:0];
               default: ;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path, one cycle after strobe
   logic [31:0] rmux;
   always_comb
   begin
      case (addr)
         CTR_REG_CTRL: rmux = {31'h0, no_retry};
         CTR_REG_OBJ: rmux = {27'h0, obj};
         CTR_REG_ID: rmux = {21'h0, id};
         CTR_REG_DLC: rmux = {28'h0, dlc};
         CTR_REG_DLO: rmux = data[31:0];
         CTR_REG_DHI: rmux = data[63:32];
         CTR_REG_FLAGS: rmux = {29'h0, flags};
         CTR_REG_TXRQ: rmux = lnk.transmit_request;
         CTR_REG_NEWD: rmux = lnk.new_data_flag;
         CTR_REG_IPND: rmux = lnk.interrupt_pending;
         CTR_REG_STAT: rmux = {31'h0, lnk.busy};
         default: rmux = 32'h0;
      endcase
   end
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         rdata <= 32'h0;
      else
         rdata <= rd ? rmux : 32'h0;
   end

   assign lnk.load_valid = load_v;
   assign lnk.load_obj = obj;
   assign lnk.load_id = id;
   assign lnk.load_dlc = dlc;
   assign lnk.load_data = data;
   assign lnk.load_transmit_request = flags[CTR_F_TXRQ];
   assign lnk.load_new_data_flag = flags[CTR_F_NEWD];
   assign lnk.load_transmit_interrupt_enable = flags[CTR_F_IRQEN];
   assign lnk.dis_valid = dis_v;
   assign lnk.dis_enable = dis_en;
   assign lnk.dis_obj = obj;
   assign lnk.disable_auto_retransmit = no_retry;
endmodule : ctr_host

// [verification/ctr_assertions.sv]
`timescale 1ns/1ps
module ctr_assertions
   import ctr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Link
   input wire logic load_valid,
   input wire logic [CTR_OBJ_W-1:0] load_obj,
   input wire logic load_transmit_request,
   input wire logic load_new_data_flag,
   input wire logic dis_valid,
   input wire logic [CTR_NUM_OBJ-1:0] transmit_request,
   input wire logic [CTR_NUM_OBJ-1:0] new_data_flag,
   input wire logic [CTR_NUM_OBJ-1:0] interrupt_pending,
   input wire logic busy,
   input wire logic tx_start
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////
   // Cycles since the last frame start, saturating
   logic [7:0] gap;
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         gap <= 8'hFF;
      else if (tx_start)
         gap <= 8'h00;
      else if (gap != 8'hFF)
         gap <= gap + 8'h01;
   end
   a_start_pulse: assert property (tx_start |=> !tx_start)
      else $error("frame start longer than one cycle");
   a_start_busy: assert property (tx_start |-> busy)
      else $error("frame start while handler idle");
   a_idle_no_start: assert property (!busy |=> !tx_start)
      else $error("frame start without preparation");
   a_start_gap: assert property (tx_start |-> gap > 8'(CTR_PREP_CYC))
      else $error("frame starts too close together");
   a_load_request: assert property (load_valid |=>
      transmit_request[$past(load_obj)] == $past(load_transmit_request))
      else $error("load did not set request");
   a_load_newdata: assert property (load_valid |=>
      new_data_flag[$past(load_obj)] == $past(load_new_data_flag))
      else $error("load did not set new data");
   a_newd_kept: assert property (!$past(load_valid) |->
      ((($past(new_data_flag) & ~new_data_flag)
      & ~($past(transmit_request) & ~transmit_request)) == '0))
      else $error("new data lost without request clear");
   a_ipnd_on_send: assert property (!$past(load_valid) |->
      $onehot0(interrupt_pending & ~$past(interrupt_pending))
      && (((interrupt_pending & ~$past(interrupt_pending)) == '0)
      || ($past(busy) && !busy)))
      else $error("pending set without a send");
   a_ipnd_kept: assert property (!$past(load_valid) |->
      (($past(interrupt_pending) & ~interrupt_pending) == '0))
      else $error("pending cleared by handler");
   c_start: cover property (tx_start);
   c_disable: cover property (dis_valid);
   c_pending: cover property ($rose(interrupt_pending != '0));
endmodule : ctr_assertions

// [verification/can_transmit_request_handling_bench.sv]
`timescale 1ns/1ps
module can_transmit_request_handling_bench
   import ctr_pkg::*;
;
   logic ref_clk, rstn, wr, rd, bus_activity, bus_error, tx_start;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [CTR_OBJ_W-1:0] tx_obj;
   logic [CTR_ID_W-1:0] tx_id;
   logic [CTR_DLC_W-1:0] tx_dlc;
   logic [CTR_DATA_W-1:0] tx_data;
   logic [31:0] objq[$];
   logic [31:0] idq[$];
   logic [CTR_DATA_W-1:0] dq[$];
   logic [31:0] eo[4] = '{32'h9, 32'h2, 32'h5, 32'h9};
   // Length code above the identifier
   logic [31:0] ei[4] = '{32'h0AA, 32'h4155, 32'h4155, 32'h4155};
   int error_cnt = 0;
   int samples_checked = 0;
   int cyc = 0;
   ctr_link_if lnk ();
   ctr_host u_ctr_host (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .lnk(lnk));
   ctr_device u_ctr_device (.ref_clk(ref_clk), .rstn(rstn), .lnk(lnk),
      .bus_activity(bus_activity), .bus_error(bus_error), .tx_start(tx_start),
      .tx_obj(tx_obj), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));
   ctr_assertions u_ctr_assertions (.ref_clk(ref_clk), .rstn(rstn),
      .load_valid(lnk.load_valid), .load_obj(lnk.load_obj),
      .load_transmit_request(lnk.load_transmit_request),
      .load_new_data_flag(lnk.load_new_data_flag), .dis_valid(lnk.dis_valid),
      .transmit_request(lnk.transmit_request), .new_data_flag(lnk.new_data_flag),
      .interrupt_pending(lnk.interrupt_pending), .busy(lnk.busy), .tx_start(tx_start));
   ////////////////////////////////////////
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      if (tx_start === 1'b1)
      begin
         objq.push_back(32'(tx_obj));
         idq.push_back(32'({tx_dlc, tx_id}));
         dq.push_back(tx_data);
      end
   end
   // Hang guard, well above the whole sequence
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 chk(n, e, rdata);
   endtask : rchk
   // Id, length and data registers keep their last values between loads
   task automatic ld(input int o, input logic [2:0] f);
      wreg(CTR_REG_OBJ, 32'(o));
      wreg(CTR_REG_FLAGS, 32'(f));
      wreg(CTR_REG_CMD, 32'(CTR_CMD_LOAD));
   endtask : ld
   task automatic wait_idle();
      int n;
      n = 0;
      repeat (3) @(posedge ref_clk);
      do
      begin
         @(posedge ref_clk);
         #1 n++;
      end
      while ((lnk.busy !== 1'b0 || lnk.transmit_request !== '0) && n < 2000);
      if (n >= 2000)
         error_cnt++;
   endtask : wait_idle
   task automatic wait_start();
      int n;
      n = 0;
      while (tx_start !== 1'b1 && n < 500)
      begin
         @(posedge ref_clk);
         #1 n++;
      end
      if (n >= 500)
         error_cnt++;
   endtask : wait_start
   ////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      rstn = 1'b0;
      {addr, wdata, wr, rd, bus_activity, bus_error} = '0;
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      wreg(4'hC, 32'hFFFFFFFF);
      rchk("ctrl", CTR_REG_CTRL, 32'h0);
      rchk("unmapped", 4'hC, 32'h0);
      rchk("newd", CTR_REG_NEWD, 32'h0);
      // Reload of a sending object, then two lower ones queued behind it
      wreg(CTR_REG_ID, 32'h0AA);
      ld(9, 3'b111);
      wait_start();
      rchk("busy", CTR_REG_STAT, 32'h1);
      wreg(CTR_REG_ID, 32'h155);
      wreg(CTR_REG_DLC, 32'h8);
      wreg(CTR_REG_DLO, 32'h0000BEEF);
      wreg(CTR_REG_DHI, 32'h12345678);
      ld(9, 3'b111);
      ld(5, 3'b011);
      ld(2, 3'b111);
      wait_idle();
      chk("sent", 32'h4, 32'(objq.size()));
      for (int i = 0; i < 4; i++)
      begin
         chk("obj", eo[i], objq[i]);
         chk("id", ei[i], idq[i]);
         chk("dlo", i == 0 ? 32'h0 : 32'h0000BEEF, dq[i][31:0]);
         chk("dhi", i == 0 ? 32'h0 : 32'h12345678, dq[i][63:32]);
      end
      rchk("idle", CTR_REG_STAT, 32'h0);
      rchk("txrq", CTR_REG_TXRQ, 32'h0);
      rchk("ipnd", CTR_REG_IPND, 32'h204);
      // Burst of four requests with retransmission off
      objq.delete();
      wreg(CTR_REG_CTRL, 32'h1);
      for (int i = 1; i <= 4; i++)
         ld(i, 3'b111);
      wait_idle();
      chk("burst", 32'h2, 32'(objq.size()));
      chk("first", 32'h1, objq[0]);
      chk("second", 32'h2, objq[1]);
      rchk("newd", CTR_REG_NEWD, 32'h18);
      rchk("ipnd", CTR_REG_IPND, 32'h206);
      // Disturbed frame: dropped with retransmission off, retried with it on
      for (int d = 1; d >= 0; d--)
      begin
         objq.delete();
         wreg(CTR_REG_CTRL, 32'(d));
         ld(6, 3'b011);
         wait_start();
         repeat (3) @(posedge ref_clk);
         bus_error <= 1'b1;
         repeat (4) @(posedge ref_clk);
         bus_error <= 1'b0;
         wait_idle();
         chk("tries", 32'(2 - d), 32'(objq.size()));
         if (d == 1)
         begin
            ld(6, 3'b011);
            wait_idle();
            chk("again", 32'h2, 32'(objq.size()));
         end
      end
      // Disable then enable during preparation; 30 must not stick
      for (int k = 0; k < 3; k++)
      begin
         objq.delete();
         ld(k == 2 ? 30 : 31, 3'b011);
         wreg(CTR_REG_CMD, 32'(CTR_CMD_DISABLE));
         wreg(CTR_REG_CMD, 32'(CTR_CMD_ENABLE));
         repeat (80) @(posedge ref_clk);
         chk("held", 32'(k == 2), 32'(objq.size()));
         rchk("stuck", CTR_REG_TXRQ, k == 2 ? 32'h0 : 32'h80000000);
         if (k == 0)
         begin
            bus_activity <= 1'b1;
            repeat (4) @(posedge ref_clk);
            bus_activity <= 1'b0;
         end
         if (k == 1)
            ld(7, 3'b011);
         wait_idle();
         chk("freed", 32'(k == 1 ? 2 : 1), 32'(objq.size()));
      end
      end_of_test();
   end
endmodule : can_transmit_request_handling_bench
